/* ptm_monitor.sv */
// Port stall time-out monitor with error flags and interrupt
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module ptm_monitor (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // Register port
  input  wire logic [15:0] ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // Peripheral access handshake
  input  wire logic        PE_START,
  input  wire logic        PE_DMA,
  input  wire logic        PE_ACK,
  // External memory access handshake
  input  wire logic        EM_START,
  input  wire logic        EM_INSTRUCTION_CACHE,
  input  wire logic        EM_ACK,
  // Cache and idle status
  input  wire logic        CACHE_OK,
  input  wire logic        IDLE_EXEC,
  input  wire logic        CPU_IDLE,
  input  wire logic        IC_PENDING,
  input  wire logic        WAKE,
  // Error delivery
  output logic             PE_TO_CPU,
  output logic             PE_TO_DMA,
  output logic             DMA_TO_SET,
  output logic             EM_TO,
  output logic             BUS_ERR,
  // Instruction port state
  output logic             IP_IDLE,
  output logic             IP_ACCEPT,
  // Interrupt
  output logic             IRQ
);
  logic [1:0]               rs_r;
  logic                     rst_n;
  logic                     pen_r;
  logic                     een_r;
  logic                     rsv4_r;
  logic                     cwork_r;
  logic                     ipi_r;
  logic                     dperr_r;
  logic                     iperr_r;
  logic                     xberr_r;
  logic                     pe_dma_r;
  logic                     em_ic_r;
  logic [ptm_pkg::IRQ_W-1:0] ist_r;
  logic [ptm_pkg::IRQ_W-1:0] imsk_r;
  logic [ptm_pkg::IRQ_W-1:0] ist_nxt;
  logic [ptm_pkg::IRQ_W-1:0] evt;
  logic [15:0]              rd_nxt;
  logic                     idle_err;
  logic                     ip_idle_w;
  logic                     ip_acc_w;

  ptm_stall_if pe_if ();
  ptm_stall_if em_if ();

  // Address compare
  function automatic logic sel(input logic [15:0] a,
                               input logic [15:0] ofs);
    sel = (a == ofs);
  endfunction

  // Reset release through two flops
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rs_r <= 2'b00;
    end else begin
      rs_r <= {rs_r[0], 1'b1};
    end
  end
  assign rst_n = rs_r[1];

  // Address decode
  wire s_xb = sel(ADDR, ptm_pkg::XBERR_OFS);
  wire s_dp = sel(ADDR, ptm_pkg::DPERR_OFS);
  wire s_ip = sel(ADDR, ptm_pkg::IPERR_OFS);
  wire s_sy = sel(ADDR, ptm_pkg::SYSST_OFS);
  wire s_to = sel(ADDR, ptm_pkg::TOCTL_OFS);
  wire s_is = sel(ADDR, ptm_pkg::IST_OFS);
  wire s_im = sel(ADDR, ptm_pkg::IMSK_OFS);
  wire s_id = sel(ADDR, ptm_pkg::IDCTL_OFS);
  wire w_sy = WR && s_sy;
  wire w_to = WR && s_to;
  wire w_is = WR && s_is;
  wire w_im = WR && s_im;
  wire w_id = WR && s_id;

  // Timer hookup
  assign pe_if.start = PE_START;
  assign pe_if.ack   = PE_ACK;
  assign pe_if.en    = pen_r;
  assign em_if.start = EM_START;
  assign em_if.ack   = EM_ACK;
  assign em_if.en    = een_r;

  ptm_stall_timer u_pe_tmr (
    .clk   (MCLK),
    .rst_n (rst_n),
    .sif   (pe_if.timer)
  );

  ptm_stall_timer u_em_tmr (
    .clk   (MCLK),
    .rst_n (rst_n),
    .sif   (em_if.timer)
  );

  ptm_instruction_port_idle u_idle (
    .clk        (MCLK),
    .rst_n      (rst_n),
    .idle_bit   (ipi_r),
    .idle_exec  (IDLE_EXEC),
    .cpu_idle   (CPU_IDLE),
    .ic_pending (IC_PENDING),
    .wake       (WAKE),
    .idle       (ip_idle_w),
    .accept     (ip_acc_w),
    .bus_error_interrupt       (idle_err)
  );

  // Requester capture at access start
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pe_dma_r <= 1'b0;
      em_ic_r  <= 1'b0;
    end else begin
      pe_dma_r <= PE_START ? PE_DMA : pe_dma_r;
      em_ic_r  <= EM_START ? EM_INSTRUCTION_CACHE : em_ic_r;
    end
  end

  // Control registers
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pen_r  <= ptm_pkg::PEN_RST;
      een_r  <= ptm_pkg::EEN_RST;
      rsv4_r <= ptm_pkg::RSV4_RST;
      ipi_r  <= 1'b0;
      imsk_r <= '0;
    end else begin
      if (w_to) begin
        pen_r <= WDATA[ptm_pkg::PEN_BIT];
        een_r <= WDATA[ptm_pkg::EEN_BIT];
      end
      if (w_sy) begin
        rsv4_r <= WDATA[ptm_pkg::RSV4_BIT];
      end
      if (w_id) begin
        ipi_r <= WDATA[ptm_pkg::IPI_BIT];
      end
      if (w_im) begin
        imsk_r <= WDATA[ptm_pkg::IRQ_W-1:0];
      end
    end
  end

  // Cache state sample
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cwork_r <= 1'b0;
    end else begin
      cwork_r <= CACHE_OK;
    end
  end

  // Sticky error flags, cleared by reset only
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      dperr_r <= 1'b0;
      iperr_r <= 1'b0;
      xberr_r <= 1'b0;
    end else begin
      dperr_r <= dperr_r || em_if.hit;
      iperr_r <= iperr_r || (em_if.hit && em_ic_r);
      xberr_r <= xberr_r || pe_if.hit;
    end
  end

  // Interrupt status, set wins over write-one clear
  assign evt[ptm_pkg::IRQ_PTO] = pe_if.hit;
  assign evt[ptm_pkg::IRQ_ETO] = em_if.hit;
  assign evt[ptm_pkg::IRQ_IDE] = idle_err;
  assign ist_nxt = (ist_r & ~(w_is ? WDATA[ptm_pkg::IRQ_W-1:0]
                                   : '0)) | evt;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= '0;
      IRQ   <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      IRQ   <= |(ist_nxt & imsk_r);
    end
  end

  // Error delivery to requesters
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      PE_TO_CPU  <= 1'b0;
      PE_TO_DMA  <= 1'b0;
      DMA_TO_SET <= 1'b0;
      EM_TO      <= 1'b0;
      BUS_ERR    <= 1'b0;
      IP_IDLE    <= 1'b0;
      IP_ACCEPT  <= 1'b1;
    end else begin
      PE_TO_CPU  <= pe_if.hit && !pe_dma_r;
      PE_TO_DMA  <= pe_if.hit && pe_dma_r;
      DMA_TO_SET <= pe_if.hit && pe_dma_r;
      EM_TO      <= em_if.hit;
      BUS_ERR    <= (pe_if.hit && !pe_dma_r) || idle_err;
      IP_IDLE    <= ip_idle_w;
      IP_ACCEPT  <= ip_acc_w;
    end
  end

  // Read data select, reserved bits zero except in the system status register
  always_comb begin
    rd_nxt = 16'h0000;
    if (s_xb) begin
      rd_nxt[ptm_pkg::FLAG_BIT] = xberr_r;
    end else if (s_dp) begin
      rd_nxt[ptm_pkg::FLAG_BIT] = dperr_r;
    end else if (s_ip) begin
      rd_nxt[ptm_pkg::FLAG_BIT] = iperr_r;
    end else if (s_sy) begin
      rd_nxt[15:6] = ptm_pkg::SYS_HI_RV;
      rd_nxt[ptm_pkg::CWORK_BIT] = cwork_r;
      rd_nxt[ptm_pkg::RSV4_BIT]  = rsv4_r;
    end else if (s_to) begin
      rd_nxt[ptm_pkg::PEN_BIT] = pen_r;
      rd_nxt[ptm_pkg::EEN_BIT] = een_r;
    end else if (s_is) begin
      rd_nxt[ptm_pkg::IRQ_W-1:0] = ist_r;
    end else if (s_im) begin
      rd_nxt[ptm_pkg::IRQ_W-1:0] = imsk_r;
    end else if (s_id) begin
      rd_nxt[ptm_pkg::IPI_BIT] = ipi_r;
    end
  end

  // Read data for one cycle after the strobe
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rd_nxt : 16'h0000;
    end
  end

  // Checks
  AST_DP_SET: assert property (@(posedge MCLK) disable iff (!rst_n)
    em_if.hit |=> dperr_r && EM_TO)
    else $error("data port flag not set on time-out");

  AST_STICKY: assert property (@(posedge MCLK) disable iff (!rst_n)
    dperr_r && iperr_r |=> dperr_r && iperr_r)
    else $error("error flag dropped before reset");

  AST_IC_SET: assert property (@(posedge MCLK) disable iff (!rst_n)
    em_if.hit && em_ic_r |=> iperr_r)
    else $error("fetch flag not set on cache time-out");

  AST_EM_GATE: assert property (@(posedge MCLK) disable iff (!rst_n)
    $rose(dperr_r) |-> $past(een_r, 2))
    else $error("memory time-out while disabled");

  AST_PE_GATE: assert property (@(posedge MCLK) disable iff (!rst_n)
    $rose(xberr_r) |-> $past(pen_r, 2))
    else $error("peripheral time-out while disabled");

  AST_CPU_BUS_ERROR_INTERRUPT: assert property (@(posedge MCLK) disable iff (!rst_n)
    pe_if.hit && !pe_dma_r |=> BUS_ERR && PE_TO_CPU && !PE_TO_DMA)
    else $error("cpu time-out gave no bus error");

  AST_DMA_TO: assert property (@(posedge MCLK) disable iff (!rst_n)
    pe_if.hit && pe_dma_r |=> DMA_TO_SET && ist_r[ptm_pkg::IRQ_PTO])
    else $error("dma time-out not flagged");

  AST_IDLE_ERR: assert property (@(posedge MCLK) disable iff (!rst_n)
    idle_err |=> BUS_ERR && ist_r[ptm_pkg::IRQ_IDE])
    else $error("idle entry error not raised");

  AST_NO_ACC: assert property (@(posedge MCLK) disable iff (!rst_n)
    IP_IDLE |-> !IP_ACCEPT)
    else $error("idle port still accepting");

  AST_CWORK: assert property (@(posedge MCLK) disable iff (!rst_n)
    RD && s_sy |=> RDATA[ptm_pkg::CWORK_BIT] == $past(CACHE_OK, 2))
    else $error("cache working bit wrong");

  AST_RSV: assert property (@(posedge MCLK) disable iff (!rst_n)
    RD && (s_dp || s_ip || s_to) |=> RDATA[15:13] == 3'h0
      && RDATA[11:2] == 10'h000)
    else $error("reserved bits not zero");

  AST_IRQ_LVL: assert property (@(posedge MCLK) disable iff (!rst_n)
    !w_im |=> IRQ == |(ist_r & imsk_r))
    else $error("interrupt level wrong");

  AST_IST_SET: assert property (@(posedge MCLK) disable iff (!rst_n)
    (|evt) |=> (ist_r & $past(evt)) == $past(evt))
    else $error("status bit lost its event");

  AST_PE_ACK: assert property (@(posedge MCLK) disable iff (!rst_n)
    PE_ACK && !PE_START |=> !pe_if.hit)
    else $error("peripheral time-out after acknowledge");

  AST_EM_ACK: assert property (@(posedge MCLK) disable iff (!rst_n)
    EM_ACK && !EM_START |=> !em_if.hit)
    else $error("memory time-out after acknowledge");

  AST_PE_OFF: assert property (@(posedge MCLK) disable iff (!rst_n)
    !pen_r |=> !pe_if.hit)
    else $error("peripheral time-out while off");

  AST_EM_OFF: assert property (@(posedge MCLK) disable iff (!rst_n)
    !een_r |=> !em_if.hit)
    else $error("memory time-out while off");

  AST_TO_PULSE: assert property (@(posedge MCLK) disable iff (!rst_n)
    PE_TO_CPU || PE_TO_DMA |=> !PE_TO_CPU && !PE_TO_DMA)
    else $error("time-out pulse longer than one cycle");

  AST_WAKE: assert property (@(posedge MCLK) disable iff (!rst_n)
    IP_IDLE && WAKE |=> ##1 IP_ACCEPT)
    else $error("port not accepting after wake");

  COV_PE_CPU: cover property (@(posedge MCLK) disable iff (!rst_n)
    PE_TO_CPU);
  COV_PE_DMA: cover property (@(posedge MCLK) disable iff (!rst_n)
    DMA_TO_SET);
  COV_EM_IC: cover property (@(posedge MCLK) disable iff (!rst_n)
    $rose(iperr_r));
  COV_IDLE: cover property (@(posedge MCLK) disable iff (!rst_n)
    $rose(IP_IDLE));
endmodule

/* ptm_pkg.sv */
// Constants and types for the port stall time-out monitor
package ptm_pkg;
  localparam int AW = 16;
  localparam int DW = 16;
  // Register offsets
  localparam logic [15:0] XBERR_OFS = 16'h0102;
  localparam logic [15:0] DPERR_OFS = 16'h0202;
  localparam logic [15:0] IPERR_OFS = 16'h0302;
  localparam logic [15:0] SYSST_OFS = 16'h07FD;
  localparam logic [15:0] TOCTL_OFS = 16'h9000;
  localparam logic [15:0] IST_OFS   = 16'h9002;
  localparam logic [15:0] IMSK_OFS  = 16'h9004;
  localparam logic [15:0] IDCTL_OFS = 16'h9006;
  // Field positions
  localparam int FLAG_BIT  = 12;
  localparam int CWORK_BIT = 5;
  localparam int RSV4_BIT  = 4;
  localparam int PEN_BIT   = 0;
  localparam int EEN_BIT   = 1;
  localparam int IPI_BIT   = 0;
  localparam int IRQ_PTO   = 0;
  localparam int IRQ_ETO   = 1;
  localparam int IRQ_IDE   = 2;
  localparam int IRQ_W     = 3;
  // Reset values
  localparam logic       PEN_RST   = 1'b1;
  localparam logic       EEN_RST   = 1'b0;
  localparam logic       RSV4_RST  = 1'b0;
  localparam logic [9:0] SYS_HI_RV = 10'b1000001000;
  // Stall limit in CPU clock cycles
  localparam int         TO_CYC = 512;
  localparam int         CNT_W  = 10;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_ARM  = 2'b01,
    ST_IDLE = 2'b10
  } ptm_idle_type;
endpackage

/* ptm_stall_if.sv */
// Handshake between the monitor and one stall timer
`timescale 1ns/100ps
interface ptm_stall_if;
  logic start;
  logic ack;
  logic en;
  logic hit;
  modport timer (input start, input ack, input en, output hit);
  modport owner (output start, output ack, output en, input hit);
endinterface

/* ptm_stall_timer.sv */
// Stall counter that flags an access left unanswered too long
`timescale 1ns/100ps
module ptm_stall_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Access handshake
  ptm_stall_if.timer sif
);
  logic                       busy_r;
  logic [ptm_pkg::CNT_W-1:0]  cnt_r;
  logic                       hit_r;
  wire  last = (cnt_r == ptm_pkg::CNT_W'(ptm_pkg::TO_CYC - 1));

  // Restart on start, stop on ack, fire at the limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
      hit_r  <= 1'b0;
    end else if (sif.start) begin
      busy_r <= 1'b1;
      cnt_r  <= '0;
      hit_r  <= 1'b0;
    end else begin
      busy_r <= busy_r && !sif.ack && !last;
      cnt_r  <= busy_r ? cnt_r + 1'b1 : cnt_r;
      hit_r  <= busy_r && !sif.ack && last && sif.en;
    end
  end
  assign sif.hit = hit_r;

  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    sif.start |=> busy_r && cnt_r == '0)
    else $error("stall count did not restart");
endmodule

/* ptm_instruction_port_idle.sv */
// Instruction port idle sequencing
`timescale 1ns/100ps
module ptm_instruction_port_idle (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic idle_bit,
  input  wire logic idle_exec,
  input  wire logic cpu_idle,
  input  wire logic ic_pending,
  input  wire logic wake,
  // Status
  output logic      idle,
  output logic      accept,
  output logic      bus_error_interrupt
);
  ptm_pkg::ptm_idle_type st_r;
  ptm_pkg::ptm_idle_type st_nxt;
  wire go = idle_exec && idle_bit;

  // Next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ptm_pkg::ST_RUN:  if (go) st_nxt = ptm_pkg::ST_ARM;
      ptm_pkg::ST_ARM:  if (wake) begin
        st_nxt = ptm_pkg::ST_RUN;
      end else if (!ic_pending) begin
        st_nxt = ptm_pkg::ST_IDLE;
      end
      ptm_pkg::ST_IDLE: if (wake) st_nxt = ptm_pkg::ST_RUN;
      default:          st_nxt = ptm_pkg::ST_RUN;
    endcase
  end

  // State and outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= ptm_pkg::ST_RUN;
      idle   <= 1'b0;
      accept <= 1'b1;
      bus_error_interrupt   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      idle   <= (st_nxt == ptm_pkg::ST_IDLE);
      accept <= (st_nxt != ptm_pkg::ST_IDLE);
      bus_error_interrupt   <= (st_r == ptm_pkg::ST_RUN) && go && !cpu_idle;
    end
  end
endmodule

/* ptm_partner.sv */
// Far-side model: peripheral and external memory acknowledge
`timescale 1ns/100ps
module ptm_partner (
  // Clock
  input  wire logic        clk,
  // Access starts seen from the requesters
  input  wire logic        pe_start,
  input  wire logic        em_start,
  // Answer delay in cycles, zero means a stalled target
  input  wire logic [15:0] pe_dly,
  input  wire logic [15:0] em_dly,
  // Acknowledges, one cycle each
  output logic             pe_ack,
  output logic             em_ack
);
  logic [15:0] pe_cnt = 16'h0000;
  logic [15:0] em_cnt = 16'h0000;
  // Age of the latest access; a new start restarts it
  always_ff @(posedge clk) begin
    pe_cnt <= pe_start ? 16'h0001 : pe_cnt + {15'h0000, pe_cnt != 16'h0000};
    em_cnt <= em_start ? 16'h0001 : em_cnt + {15'h0000, em_cnt != 16'h0000};
  end
  // A disabled target never answers; others answer after their delay
  assign pe_ack = (pe_dly != 16'h0000) && (pe_cnt == pe_dly);
  assign em_ack = (em_dly != 16'h0000) && (em_cnt == em_dly);
endmodule

/* test_ptm_monitor.sv */
// Self-checking bench for the port stall time-out monitor
`timescale 1ns/100ps
module test_ptm_monitor;
  logic        MCLK = 1'b0;
  logic        RSTN = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        PE_START = 1'b0;
  logic        PE_DMA = 1'b0;
  logic        EM_START = 1'b0;
  logic        EM_INSTRUCTION_CACHE = 1'b0;
  logic        CACHE_OK = 1'b0;
  logic        IDLE_EXEC = 1'b0;
  logic        CPU_IDLE = 1'b1;
  logic        IC_PENDING = 1'b0;
  logic        WAKE = 1'b0;
  logic [15:0] pe_dly = 16'h0000;
  logic [15:0] em_dly = 16'h0000;
  logic [15:0] RDATA;
  logic        PE_ACK, EM_ACK;
  logic        PE_TO_CPU, PE_TO_DMA, DMA_TO_SET, EM_TO, BUS_ERR;
  logic        IP_IDLE, IP_ACCEPT, IRQ;
  int          mismatches = 0;
  int          checks_done = 0;
  int          n;

  // Clock
  always #50 MCLK = ~MCLK;

  ptm_partner far (.clk(MCLK), .pe_start(PE_START), .em_start(EM_START),
    .pe_dly(pe_dly), .em_dly(em_dly), .pe_ack(PE_ACK), .em_ack(EM_ACK));

  ptm_monitor dut (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PE_START(PE_START), .PE_DMA(PE_DMA),
    .PE_ACK(PE_ACK), .EM_START(EM_START), .EM_INSTRUCTION_CACHE(EM_INSTRUCTION_CACHE),
    .EM_ACK(EM_ACK), .CACHE_OK(CACHE_OK), .IDLE_EXEC(IDLE_EXEC),
    .CPU_IDLE(CPU_IDLE), .IC_PENDING(IC_PENDING), .WAKE(WAKE),
    .PE_TO_CPU(PE_TO_CPU), .PE_TO_DMA(PE_TO_DMA), .DMA_TO_SET(DMA_TO_SET),
    .EM_TO(EM_TO), .BUS_ERR(BUS_ERR), .IP_IDLE(IP_IDLE),
    .IP_ACCEPT(IP_ACCEPT), .IRQ(IRQ));

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Register port cycles
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [15:0] a,
                      input logic [15:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk(nm, e, RDATA);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = PE_TO_CPU;
      1: pick = PE_TO_DMA;
      3: pick = EM_TO;
      4: pick = BUS_ERR;
      5: pick = IP_IDLE;
      default: pick = ~IP_IDLE;
    endcase
  endfunction

  // Edges counted after the taking edge until the output is high
  task automatic wait_out(input int s, input int lim, output int k);
    k = 0;
    do begin
      @(posedge MCLK);
      #1;
      k++;
    end while (pick(s) !== 1'b1 && k < lim);
  endtask

  task automatic pe_go(input logic dma);
    @(posedge MCLK);
    PE_START <= 1'b1;
    PE_DMA <= dma;
    @(posedge MCLK);
    PE_START <= 1'b0;
  endtask

  task automatic em_go(input logic ic);
    @(posedge MCLK);
    EM_START <= 1'b1;
    EM_INSTRUCTION_CACHE <= ic;
    @(posedge MCLK);
    EM_START <= 1'b0;
  endtask

  task automatic idle_go(input logic cpu);
    @(posedge MCLK);
    IDLE_EXEC <= 1'b1;
    CPU_IDLE <= cpu;
    @(posedge MCLK);
    IDLE_EXEC <= 1'b0;
  endtask

  task automatic t_reset();
    rchk("stall_timeout_control", ptm_pkg::TOCTL_OFS, 16'h0001);
    rchk("data_port_error_flags", ptm_pkg::DPERR_OFS, 16'h0000);
    rchk("instr_port_error_flags", ptm_pkg::IPERR_OFS, 16'h0000);
    rchk("crossbar_error_register", ptm_pkg::XBERR_OFS, 16'h0000);
    rchk("sys", ptm_pkg::SYSST_OFS, 16'h8200);
    rchk("unmapped", 16'h0400, 16'h0000);
  endtask

  task automatic t_regs();
    CACHE_OK <= 1'b1;
    wr(ptm_pkg::SYSST_OFS, 16'h0000);
    rchk("sys ok", ptm_pkg::SYSST_OFS, 16'h8220);
    wr(ptm_pkg::TOCTL_OFS, 16'hFFFC);
    rchk("stall_timeout_control rsv", ptm_pkg::TOCTL_OFS, 16'h0000);
    wr(ptm_pkg::TOCTL_OFS, 16'h0001);
    wr(ptm_pkg::DPERR_OFS, 16'hFFFF);
    rchk("data_port_error_flags ro", ptm_pkg::DPERR_OFS, 16'h0000);
    wr(ptm_pkg::IMSK_OFS, 16'h0007);
  endtask

  task automatic t_pe_cpu();
    pe_go(1'b0);
    wait_out(0, 600, n);
    chk("cpu to cycles", 16'd513, 16'(n));
    chk("bus err", 16'h0001, {15'h0000, BUS_ERR});
    chk("irq set", 16'h0001, {15'h0000, IRQ});
    @(posedge MCLK);
    #1;
    chk("cpu to pulse", 16'h0000, {15'h0000, PE_TO_CPU});
    rchk("crossbar_error_register flag", ptm_pkg::XBERR_OFS, 16'h1000);
    rchk("status", ptm_pkg::IST_OFS, 16'h0001);
    wr(ptm_pkg::IST_OFS, 16'h0001);
    rchk("status clr", ptm_pkg::IST_OFS, 16'h0000);
    chk("irq clr", 16'h0000, {15'h0000, IRQ});
  endtask

  task automatic t_pe_dma();
    wr(ptm_pkg::IMSK_OFS, 16'h0000);
    pe_go(1'b1);
    wait_out(1, 600, n);
    chk("dma to cycles", 16'd513, 16'(n));
    chk("dma flag", 16'h0001, {15'h0000, DMA_TO_SET});
    chk("irq masked", 16'h0000, {15'h0000, IRQ});
    wr(ptm_pkg::IMSK_OFS, 16'h0007);
    @(posedge MCLK);
    #1;
    chk("irq unmask", 16'h0001, {15'h0000, IRQ});
    wr(ptm_pkg::IST_OFS, 16'h0007);
  endtask

  task automatic t_pe_cancel();
    pe_dly <= 16'd300;
    pe_go(1'b0);
    wait_out(0, 700, n);
    chk("acked access", 16'd700, 16'(n));
    pe_dly <= 16'd0;
    pe_go(1'b0);
    repeat (200) @(posedge MCLK);
    pe_go(1'b0);
    wait_out(0, 600, n);
    chk("restart", 16'd513, 16'(n));
    wr(ptm_pkg::TOCTL_OFS, 16'h0000);
    pe_go(1'b0);
    wait_out(0, 600, n);
    chk("pe disabled", 16'd600, 16'(n));
    wr(ptm_pkg::TOCTL_OFS, 16'h0001);
    wr(ptm_pkg::IST_OFS, 16'h0007);
  endtask

  task automatic t_em();
    em_go(1'b1);
    wait_out(3, 600, n);
    chk("em disabled", 16'd600, 16'(n));
    rchk("instr_port_error_flags off", ptm_pkg::IPERR_OFS, 16'h0000);
    wr(ptm_pkg::TOCTL_OFS, 16'h0003);
    em_dly <= 16'd100;
    em_go(1'b0);
    wait_out(3, 600, n);
    chk("em acked", 16'd600, 16'(n));
    em_dly <= 16'd0;
    em_go(1'b1);
    wait_out(3, 600, n);
    chk("em to cycles", 16'd513, 16'(n));
    wr(ptm_pkg::TOCTL_OFS, 16'h0001);
    rchk("data_port_error_flags flag", ptm_pkg::DPERR_OFS, 16'h1000);
    rchk("instr_port_error_flags flag", ptm_pkg::IPERR_OFS, 16'h1000);
    rchk("em status", ptm_pkg::IST_OFS, 16'h0002);
    wr(ptm_pkg::IPERR_OFS, 16'h0000);
    rchk("instr_port_error_flags stays", ptm_pkg::IPERR_OFS, 16'h1000);
    wr(ptm_pkg::IST_OFS, 16'h0007);
  endtask

  task automatic t_idle();
    idle_go(1'b1);
    wait_out(5, 4, n);
    chk("no idle bit", 16'd4, 16'(n));
    wr(ptm_pkg::IDCTL_OFS, 16'h0001);
    IC_PENDING <= 1'b1;
    idle_go(1'b1);
    wait_out(5, 6, n);
    chk("pending holds", 16'd6, 16'(n));
    IC_PENDING <= 1'b0;
    wait_out(5, 4, n);
    chk("idle entry", 16'h0001, {15'h0000, n < 4});
    chk("no accept", 16'h0000, {15'h0000, IP_ACCEPT});
    WAKE <= 1'b1;
    @(posedge MCLK);
    WAKE <= 1'b0;
    wait_out(6, 3, n);
    chk("wake", 16'h0001, {15'h0000, IP_ACCEPT});
    idle_go(1'b0);
    wait_out(4, 4, n);
    chk("bad idle", 16'h0001, 16'(n));
    rchk("idle status", ptm_pkg::IST_OFS, 16'h0004);
    WAKE <= 1'b1;
    @(posedge MCLK);
    WAKE <= 1'b0;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge MCLK);
    mismatches++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge MCLK);
    t_reset();
    t_regs();
    t_pe_cpu();
    t_pe_dma();
    t_pe_cancel();
    t_em();
    t_idle();
    give_verdict();
  end
endmodule
